/* design/ssg_strobe_gen.sv */
// Purpose: Strobe outputs with a programmable single strobe pulse per acquisition
// Assumes: Trigger event and continuous strobe waveform come from same-clock logic
// Notes:   All times are whole microseconds, stepped from the trigger event

`timescale 1ns/1ps

module ssg_strobe_gen
	import ssg_pkg::*;
#(
	parameter logic [31:0] BUSY1_US = BUSY1_US_DEF,
	parameter logic [31:0] BUSY2_US = BUSY2_US_DEF
)
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Sequencer side
	input wire logic trig_evt_i,
	input wire logic cont_strobe_raw_i,
	// Strobe and cycle outputs
	output logic ss_o,
	output logic cs_o,
	output logic integ_o,
	output logic busy_o
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed
	{
		logic ss_en;
		logic cs_en;
		logic [31:0] ss_dly;
		logic [31:0] ss_wid;
		logic [31:0] acq_dly;
		logic [31:0] integ_us;
		logic [31:0] trig_cnt;
		ssg_ss_e ss_st;
		logic [31:0] ss_cnt;
		logic ss_out;
		logic cs_out;
		logic [31:0] rdata;
	} ssg_main_s;

	ssg_main_s st_ff;
	ssg_main_s nxt_st;

	// Signals from the two submodules
	logic us_tick;
	logic accept;
	logic seq_integ;
	logic seq_integ_end;
	logic seq_busy;
	logic [3:0] seq_phase;

	// ************************************************************
	// Submodules
	// ************************************************************
	// The step grid restarts on the accepting edge, so a delay of N steps
	// is always N whole microseconds from the trigger and never N-1 plus
	// a fraction left over from the previous cycle.
	// Microsecond steps, realigned to every accepted trigger
	ssg_us_tick u_tick
	(
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.restart_i(accept),
		.tick_o(us_tick)
	);

	// The sequencer only takes a trigger while it is idle. The strobe logic
	// uses the same accept pulse, so a trigger that the sequencer refuses
	// can never start a second strobe inside one acquisition cycle.
	// Acquisition phases that frame the integration window
	ssg_acq_seq #(
		.BUSY1_US(BUSY1_US),
		.BUSY2_US(BUSY2_US)
	) u_seq
	(
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.us_tick_i(us_tick),
		.trig_i(trig_evt_i),
		.acq_dly_i(st_ff.acq_dly),
		.integ_us_i(st_ff.integ_us),
		.accept_o(accept),
		.integ_o(seq_integ),
		.integ_end_o(seq_integ_end),
		.busy_o(seq_busy),
		.phase_o(seq_phase)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	// Register decode, read data, trigger count and both strobe outputs.
	// Every field except rdata, which starts from zero, starts from its held
	// value; only the branches below change it, so a field that is not named keeps its value.
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.rdata = 32'h0000_0000;

		// Writes to the status and trigger count offsets fall into the
		// default branch and change nothing: both are read-only.
		// Register writes
		if (wr_i)
		begin
			case (addr_i)
				OFS_CTRL:
				begin
					nxt_st.ss_en = wdata_i[CTRL_SS_EN_BIT];
					nxt_st.cs_en = wdata_i[CTRL_CS_EN_BIT];
				end
				OFS_SS_DLY:
					nxt_st.ss_dly = wdata_i;
				OFS_SS_WID:
					nxt_st.ss_wid = wdata_i;
				OFS_ACQ_DLY:
					nxt_st.acq_dly = wdata_i;
				OFS_INTEG:
					nxt_st.integ_us = wdata_i;
				default:
					nxt_st.ss_en = st_ff.ss_en;
			endcase
		end

		// Read data are zero in every cycle without a read strobe, so a
		// stale value never stays on the bus after its one valid cycle.
		// Register reads, data stand the following cycle only
		if (rd_i)
		begin
			case (addr_i)
				OFS_CTRL:
				begin
					nxt_st.rdata[CTRL_SS_EN_BIT] = st_ff.ss_en;
					nxt_st.rdata[CTRL_CS_EN_BIT] = st_ff.cs_en;
				end
				OFS_SS_DLY:
					nxt_st.rdata = st_ff.ss_dly;
				OFS_SS_WID:
					nxt_st.rdata = st_ff.ss_wid;
				OFS_ACQ_DLY:
					nxt_st.rdata = st_ff.acq_dly;
				OFS_INTEG:
					nxt_st.rdata = st_ff.integ_us;
				OFS_STATUS:
				begin
					nxt_st.rdata[ST_SS_BIT] = st_ff.ss_out;
					nxt_st.rdata[ST_CS_BIT] = st_ff.cs_out;
					nxt_st.rdata[ST_INTEG_BIT] = seq_integ;
					nxt_st.rdata[ST_BUSY_BIT] = seq_busy;
					nxt_st.rdata[ST_PH_LSB +: 4] = seq_phase;
					nxt_st.rdata[ST_SS_ST_LSB +: 3] = st_ff.ss_st;
				end
				OFS_TRIG_CNT:
					nxt_st.rdata = st_ff.trig_cnt;
				default:
					nxt_st.rdata = 32'h0000_0000;
			endcase
		end

		// The counter wraps silently after 2^32 accepted triggers; software
		// should work with differences between reads, not absolute values.
		// Count accepted acquisition cycles
		if (accept)
			nxt_st.trig_cnt = ssg_inc(st_ff.trig_cnt);

		// Enable is looked at on every cycle, not only at the trigger:
		// clearing it cuts a running pulse at once, and a trigger that
		// arrives while it is clear is lost for this strobe.
		// A pulse that starts after integration has ended is not cut; only
		// a pulse that is high at the end of integration is forced low.
		// Single strobe pulse, one per accepted trigger
		if (!st_ff.ss_en)
		begin
			nxt_st.ss_st = SSG_SS_IDLE;
			nxt_st.ss_out = 1'h0;
			nxt_st.ss_cnt = 32'h0000_0000;
		end
		else
		begin
			case (st_ff.ss_st)
				SSG_SS_IDLE:
				begin
					if (accept)
					begin
						nxt_st.ss_cnt = 32'h0000_0000;
						// Zero delay rises at once, zero width gives no pulse
						// A zero width with a zero delay leaves the state idle
						if (st_ff.ss_dly != 32'h0000_0000)
							nxt_st.ss_st = SSG_SS_WAIT;
						else if (st_ff.ss_wid != 32'h0000_0000)
						begin
							nxt_st.ss_st = SSG_SS_HIGH;
							nxt_st.ss_out = 1'h1;
						end
					end
				end
				SSG_SS_WAIT:
				begin
					// Delay runs from the trigger, not from integration
					// A delay of N waits for the Nth step after the trigger; a
					// lowered target is caught at the next step because of the >= compare
					if (us_tick && ssg_last(st_ff.ss_cnt, st_ff.ss_dly))
					begin
						nxt_st.ss_cnt = 32'h0000_0000;
						if (st_ff.ss_wid != 32'h0000_0000)
						begin
							nxt_st.ss_st = SSG_SS_HIGH;
							nxt_st.ss_out = 1'h1;
						end
						else
							nxt_st.ss_st = SSG_SS_IDLE;
					end
					else if (us_tick)
						nxt_st.ss_cnt = ssg_inc(st_ff.ss_cnt);
				end
				SSG_SS_HIGH:
				begin
					// Integration end wins over the width count when both fall
					// in the same cycle; a pulse high at integration end falls one clock after integ_o
					if (seq_integ_end)
					begin
						nxt_st.ss_st = SSG_SS_IDLE;
						nxt_st.ss_out = 1'h0;
					end
					else if (us_tick && ssg_last(st_ff.ss_cnt, st_ff.ss_wid))
					begin
						nxt_st.ss_st = SSG_SS_IDLE;
						nxt_st.ss_out = 1'h0;
					end
					else if (us_tick)
						nxt_st.ss_cnt = ssg_inc(st_ff.ss_cnt);
				end
				default:
				begin
					nxt_st.ss_st = SSG_SS_IDLE;
					nxt_st.ss_out = 1'h0;
				end
			endcase
		end

		// The waveform itself comes from other logic; this stage only gates
		// and registers it, which delays it by one clock
		// Continuous strobe gated by its own enable
		nxt_st.cs_out = st_ff.cs_en & cont_strobe_raw_i;
	end

	// ************************************************************
	// State register
	// ************************************************************
	// Synchronous reset puts every field back to its power-on value
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			st_ff.ss_en <= SS_EN_RST;
			st_ff.cs_en <= CS_EN_RST;
			st_ff.ss_dly <= SS_DLY_RST;
			st_ff.ss_wid <= SS_WID_RST;
			st_ff.acq_dly <= ACQ_DLY_RST;
			st_ff.integ_us <= INTEG_RST;
			st_ff.trig_cnt <= 32'h0000_0000;
			st_ff.ss_st <= SSG_SS_IDLE;
			st_ff.ss_cnt <= 32'h0000_0000;
			st_ff.ss_out <= 1'h0;
			st_ff.cs_out <= 1'h0;
			st_ff.rdata <= 32'h0000_0000;
		end
		else
			st_ff <= nxt_st;
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	// Data outputs come from flip-flops; integ_o and busy_o are decoded
	// from the sequencer's phase flip-flops
	assign rdata_o = st_ff.rdata;
	assign ss_o = st_ff.ss_out;
	assign cs_o = st_ff.cs_out;
	assign integ_o = seq_integ;
	assign busy_o = seq_busy;

endmodule

/* include/ssg_pkg.sv */
// Purpose: Shared constants, types and helpers of the single strobe generator
// Assumes: 10 MHz system clock, 32-bit register data, byte addressed word registers
// Notes:   Times held in registers are whole microseconds

package ssg_pkg;

	// ************************************************************
	// Clock and time base
	// ************************************************************
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned US_NS = 1000;
	// Cycles per microsecond step, rounded up, never below one
	localparam int unsigned CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] US_DIV_LAST = 4'(CYC_PER_US - 1);

	// Fixed busy phases of an acquisition cycle, in microseconds
	localparam logic [31:0] BUSY1_US_DEF = 32'h0000_0446; // 1094 us
	localparam logic [31:0] BUSY2_US_DEF = 32'h0000_040E; // 1038 us

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SS_DLY = 8'h04;
	localparam logic [7:0] OFS_SS_WID = 8'h08;
	localparam logic [7:0] OFS_ACQ_DLY = 8'h0C;
	localparam logic [7:0] OFS_INTEG = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_TRIG_CNT = 8'h18;

	// Field positions
	localparam int unsigned CTRL_SS_EN_BIT = 0;
	localparam int unsigned CTRL_CS_EN_BIT = 1;
	localparam int unsigned ST_SS_BIT = 0;
	localparam int unsigned ST_CS_BIT = 1;
	localparam int unsigned ST_INTEG_BIT = 2;
	localparam int unsigned ST_BUSY_BIT = 3;
	localparam int unsigned ST_PH_LSB = 4;
	localparam int unsigned ST_SS_ST_LSB = 8;

	// Reset values
	localparam logic SS_EN_RST = 1'h0;
	localparam logic CS_EN_RST = 1'h0;
	localparam logic [31:0] SS_DLY_RST = 32'h0000_0000;
	localparam logic [31:0] SS_WID_RST = 32'h0000_0000;
	localparam logic [31:0] ACQ_DLY_RST = 32'h0000_0000;
	localparam logic [31:0] INTEG_RST = 32'h0000_03E8; // 1000 us

	// ************************************************************
	// State encodings
	// ************************************************************
	typedef enum logic [2:0]
	{
		SSG_SS_IDLE = 3'b001,
		SSG_SS_WAIT = 3'b010,
		SSG_SS_HIGH = 3'b100
	} ssg_ss_e;

	typedef enum logic [3:0]
	{
		SSG_PH_IDLE = 4'b0001,
		SSG_PH_PRE = 4'b0010,
		SSG_PH_INTEG = 4'b0100,
		SSG_PH_POST = 4'b1000
	} ssg_ph_e;

	// ************************************************************
	// Helpers
	// ************************************************************
	// True when one more step reaches or passes the target
	function automatic logic ssg_last(input logic [31:0] cnt, input logic [31:0] tgt);
		ssg_last = (cnt + 32'h0000_0001) >= tgt;
	endfunction

	// Counter step
	function automatic logic [31:0] ssg_inc(input logic [31:0] cnt);
		ssg_inc = cnt + 32'h0000_0001;
	endfunction

endpackage

/* design/ssg_us_tick.sv */
// Purpose: Microsecond step divider for the strobe generator
// Assumes: Same clock as the rest of the block
// Notes:   A restart realigns the step grid to the trigger event

`timescale 1ns/1ps

module ssg_us_tick
	import ssg_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Control
	input wire logic restart_i,
	// Step output
	output logic tick_o
);

	typedef struct packed
	{
		logic [3:0] cnt;
		logic tick;
	} ssg_tick_s;

	ssg_tick_s st_ff;
	ssg_tick_s nxt_st;

	// Divide the clock into one pulse per microsecond
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.tick = 1'h0;
		if (restart_i)
		begin
			nxt_st.cnt = 4'h0;
		end
		else if (st_ff.cnt == US_DIV_LAST)
		begin
			nxt_st.cnt = 4'h0;
			nxt_st.tick = 1'h1;
		end
		else
		begin
			nxt_st.cnt = st_ff.cnt + 4'h1;
		end
	end

	// State register
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign tick_o = st_ff.tick;

endmodule

/* design/ssg_acq_seq.sv */
// Purpose: Acquisition cycle phases: initial delay, integration, final busy
// Assumes: One microsecond step pulse, restarted on each accepted trigger
// Notes:   Triggers arriving during a cycle are not accepted

`timescale 1ns/1ps

module ssg_acq_seq
	import ssg_pkg::*;
#(
	parameter logic [31:0] BUSY1_US = BUSY1_US_DEF,
	parameter logic [31:0] BUSY2_US = BUSY2_US_DEF
)
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Timing inputs
	input wire logic us_tick_i,
	input wire logic trig_i,
	input wire logic [31:0] acq_dly_i,
	input wire logic [31:0] integ_us_i,
	// Cycle status
	output logic accept_o,
	output logic integ_o,
	output logic integ_end_o,
	output logic busy_o,
	output logic [3:0] phase_o
);

	typedef struct packed
	{
		ssg_ph_e ph;
		logic [31:0] cnt;
		logic [31:0] tgt;
		logic integ_end;
	} ssg_seq_s;

	ssg_seq_s st_ff;
	ssg_seq_s nxt_st;

	// Trigger taken only between cycles
	assign accept_o = trig_i & (st_ff.ph == SSG_PH_IDLE);

	// Phase walk, one step per microsecond
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.integ_end = 1'h0;
		case (st_ff.ph)
			SSG_PH_IDLE:
			begin
				if (trig_i)
				begin
					nxt_st.ph = SSG_PH_PRE;
					nxt_st.cnt = 32'h0000_0000;
					nxt_st.tgt = acq_dly_i + BUSY1_US;
				end
			end
			SSG_PH_PRE:
			begin
				if (us_tick_i && ssg_last(st_ff.cnt, st_ff.tgt))
				begin
					nxt_st.ph = SSG_PH_INTEG;
					nxt_st.cnt = 32'h0000_0000;
					nxt_st.tgt = integ_us_i;
				end
				else if (us_tick_i)
					nxt_st.cnt = ssg_inc(st_ff.cnt);
			end
			SSG_PH_INTEG:
			begin
				if (us_tick_i && ssg_last(st_ff.cnt, st_ff.tgt))
				begin
					nxt_st.ph = SSG_PH_POST;
					nxt_st.cnt = 32'h0000_0000;
					nxt_st.tgt = BUSY2_US;
					nxt_st.integ_end = 1'h1;
				end
				else if (us_tick_i)
					nxt_st.cnt = ssg_inc(st_ff.cnt);
			end
			SSG_PH_POST:
			begin
				if (us_tick_i && ssg_last(st_ff.cnt, st_ff.tgt))
					nxt_st.ph = SSG_PH_IDLE;
				else if (us_tick_i)
					nxt_st.cnt = ssg_inc(st_ff.cnt);
			end
			default:
				nxt_st.ph = SSG_PH_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			st_ff.ph <= SSG_PH_IDLE;
			st_ff.cnt <= 32'h0000_0000;
			st_ff.tgt <= 32'h0000_0000;
			st_ff.integ_end <= 1'h0;
		end
		else
			st_ff <= nxt_st;
	end

	assign integ_o = (st_ff.ph == SSG_PH_INTEG);
	assign integ_end_o = st_ff.integ_end;
	assign busy_o = (st_ff.ph != SSG_PH_IDLE);
	assign phase_o = st_ff.ph;

endmodule

/* tb/ssg_ext_eq.sv */
// Purpose: Far-side equipment model: makes the continuous waveform, counts strobe pulses
// Assumes: Same clock as the block
// Notes:   Waveform half period is a plain parameter
`timescale 1ns/1ps
module ssg_ext_eq
#(
	parameter int HALF = 7
)
(
	// Clock
	input wire logic mclk_i,
	// Strobe from block
	input wire logic ss_i,
	// Waveform and pulse count
	output logic raw_o,
	output logic [31:0] pulses_o
);
	// ****************
	// Waveform and pulse counter
	// ****************
	int cnt = 0;
	logic ss_d = 1'b0;
	initial raw_o = 1'b0;
	initial pulses_o = 32'h0;
	// Toggle raw level, count rising strobe edges
	always @(posedge mclk_i)
	begin
		cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
		if (cnt == HALF - 1)
			raw_o <= ~raw_o;
		ss_d <= ss_i;
		if (ss_i && !ss_d)
			pulses_o <= pulses_o + 32'h1;
	end
endmodule

/* tb/ssg_strobe_checker.sv */
// Purpose: Port-level assertions of the strobe generator
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module from the bench
`timescale 1ns/1ps
module ssg_strobe_checker
#(
	parameter logic [31:0] BUSY1_US = 32'h2,
	parameter logic [31:0] BUSY2_US = 32'h2
)
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// Watched ports
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic trig_evt_i,
	input wire logic cont_strobe_raw_i,
	input wire logic ss_o,
	input wire logic cs_o,
	input wire logic integ_o,
	input wire logic busy_o
);
	// ****************
	// Sequences and assertions
	// ****************
	default clocking @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_accept;
		trig_evt_i && !busy_o;
	endsequence
	sequence s_pre;
		(busy_o && !integ_o) [*8];
	endsequence
	chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data not zero outside read slot");
	chk_cs_gate: assert property (!$past(cont_strobe_raw_i) |-> !cs_o)
		else $error("continuous strobe high without raw waveform");
	chk_busy_start: assert property (s_accept |=> busy_o)
		else $error("accepted trigger did not start a cycle");
	chk_pre_phase: assert property (s_accept |=> s_pre)
		else $error("integration started too early");
	chk_integ_busy: assert property (integ_o |-> busy_o)
		else $error("integration outside busy cycle");
	chk_integ_min: assert property ($rose(integ_o) |-> integ_o [*8])
		else $error("integration shorter than one step");
	chk_post_hold: assert property ($fell(integ_o) |-> busy_o [*8])
		else $error("final busy phase missing");
	chk_trunc_end: assert property ($fell(integ_o) |-> ##[0:3] !ss_o)
		else $error("strobe not cut at integration end");
endmodule

/* tb/test_single_strobe_generator.sv */
// Purpose: Self-checking bench of the single strobe generator
// Assumes: Busy phases shortened to 2 us
// Notes:   Cycle counts start at the trigger cycle
`timescale 1ns/1ps
module test_single_strobe_generator import ssg_pkg::*;;
	// ****************
	// Signals and instances
	// ****************
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic trig_evt_i = 1'b0;
	logic cont_strobe_raw_i, ss_o, cs_o, integ_o, busy_o;
	logic [31:0] rdata_o, pulses, rv;
	logic raw_q = 1'b0;
	int cs_bad = 0;
	int err_total = 0;
	int checked = 0;
	int seed = 32'h5B1DB8AE;
	int n_acq = 0;
	ssg_strobe_gen #(.BUSY1_US(32'h2), .BUSY2_US(32'h2)) dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.trig_evt_i(trig_evt_i), .cont_strobe_raw_i(cont_strobe_raw_i), .ss_o(ss_o), .cs_o(cs_o),
		.integ_o(integ_o), .busy_o(busy_o));
	ssg_ext_eq ext_u (.mclk_i(mclk_i), .ss_i(ss_o), .raw_o(cont_strobe_raw_i), .pulses_o(pulses));
	// Raw waveform as the block sampled it at the last edge
	always @(posedge mclk_i)
		raw_q <= cont_strobe_raw_i;
	// Clock
	initial forever #50 mclk_i = ~mclk_i;
	// ****************
	// Tasks and expectations
	// ****************
	task cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e)
		begin
			err_total++;
			$display("BAD %s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task cmpr(input string nm, input int lo, input int hi, input int s);
		checked++;
		if (s < lo || s > hi)
		begin
			err_total++;
			$display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 cmp("rdata", e, rdata_o);
	endtask
	function automatic int exp_rise(input int d, input int w, input int en);
		if (en == 0 || w == 0)
			return 0;
		return (d == 0) ? 1 : 10 * d + 2;
	endfunction
	function automatic int exp_fall(input int d, input int w, input int a, input int i, input int en);
		int r, nm, ie;
		r = exp_rise(d, w, en);
		nm = r + 10 * w;
		ie = 10 * (a + 2 + ((i == 0) ? 1 : i)) + 2;
		if (r == 0)
			return 0;
		return (nm > ie && r < ie) ? ie : nm;
	endfunction
	// One acquisition with a refused second trigger while busy
	task acq(input int d, input int w, input int a, input int i, input int en);
		int n, r, f, ir, ef, e, p0;
		wr(OFS_SS_DLY, 32'(d));
		wr(OFS_SS_WID, 32'(w));
		wr(OFS_ACQ_DLY, 32'(a));
		wr(OFS_INTEG, 32'(i));
		wr(OFS_CTRL, 32'(2 + en));
		p0 = pulses;
		cs_bad = 0;
		@(posedge mclk_i);
		trig_evt_i <= 1'b1;
		@(posedge mclk_i);
		trig_evt_i <= 1'b0;
		n = 1;
		r = 0;
		f = 0;
		ir = 0;
		#1;
		while (busy_o === 1'b1 && n < 4000)
		begin
			if (ss_o === 1'b1 && r == 0)
				r = n;
			if (ss_o === 1'b0 && r != 0 && f == 0)
				f = n;
			if (integ_o === 1'b1 && ir == 0)
				ir = n;
			if (cs_o !== raw_q)
				cs_bad++;
			@(posedge mclk_i);
			trig_evt_i <= (n == 39);
			n++;
			#1;
		end
		n_acq++;
		e = (i == 0) ? 1 : i;
		ef = exp_fall(d, w, a, i, en);
		cmpr("rise", exp_rise(d, w, en), exp_rise(d, w, en), r);
		cmpr("fall", ef, (ef == 0) ? 0 : ef + 3, f);
		cmpr("integ_start", 10 * (a + 2) + 1, 10 * (a + 2) + 3, ir);
		cmpr("busy_len", 10 * (a + 4 + e), 10 * (a + 4 + e) + 3, n);
		cmp("pulses", (en != 0 && w != 0) ? 32'h1 : 32'h0, pulses - p0);
		cmp("cs_follow", 32'h0, 32'(cs_bad));
		$display("acq done dly=%0d wid=%0d acq=%0d integ=%0d en=%0d", d, w, a, i, en);
	endtask
	task report_and_stop();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ****************
	// Main sequence and watchdog
	// ****************
	initial
	begin
		repeat (16) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		rd(OFS_CTRL, 32'h0);
		rd(OFS_INTEG, INTEG_RST);
		rd(OFS_SS_DLY, SS_DLY_RST);
		rd(8'h1C, 32'h0);
		wr(OFS_STATUS, 32'hFFFFFFFF);
		rd(OFS_STATUS, 32'h00000110);
		rv = $random(seed);
		wr(OFS_SS_WID, rv);
		rd(OFS_SS_WID, rv);
		wr(OFS_SS_WID, 32'hA5C3961E);
		rd(OFS_SS_WID, 32'hA5C3961E);
		cmp("cs_off", 32'h0, {31'h0, cs_o});
		$display("register test done");
		acq(0, 1, 0, 0, 1);
		acq(1, 40, 1, 3, 1);
		acq(1, 2, 2, 5, 1);
		acq(2, 1, 0, 5, 0);
		acq(3, 0, 0, 6, 1);
		repeat (12)
			acq($random(seed) & 7, 1 + ($random(seed) & 7), $random(seed) & 1, 6 + ($random(seed) & 7), 1);
		rd(OFS_TRIG_CNT, 32'(n_acq));
		report_and_stop();
	end
	initial
	begin
		repeat (40000) @(posedge mclk_i);
		err_total++;
		report_and_stop();
	end
endmodule
bind ssg_strobe_gen ssg_strobe_checker #(.BUSY1_US(BUSY1_US), .BUSY2_US(BUSY2_US)) chk_u (.mclk_i(mclk_i),
	.sys_rst_i(sys_rst_i), .rd_i(rd_i), .rdata_o(rdata_o), .trig_evt_i(trig_evt_i),
	.cont_strobe_raw_i(cont_strobe_raw_i), .ss_o(ss_o), .cs_o(cs_o), .integ_o(integ_o), .busy_o(busy_o));
